// ---- src/drive_end.sv ----
/*
 * drive end: decodes control words into state moves, encodes each state
 * as a status word, drives brake and axis enable, and handles restore keys.
 * assumes init_done, fault, halt_done and actual_fb come from logic on clk,
 * so they are used without synchronisers.
 */
`timescale 1ns/1ps
`include "drive_params.svh"
module drive_end
	import drive_pkg::*;
#(
	parameter int FB_W = 32
) (
	input  wire logic        clk,
	input  wire logic        reset,
	drive_link_if.drive      link,
	input  wire logic        init_done,
	input  wire logic        fault,
	input  wire logic        halt_done,
	input  wire logic [FB_W-1:0] actual_fb,
	output logic             brake,
	output logic             axis_enable,
	output logic [3:0]       restore_pulse
);

	generate
		if (FB_W < 8 || FB_W > 32) begin : g_bad_width
			$error("drive_end: FB_W must lie in 8..32");
		end
	endgenerate

	drive_state_t    state;
	drive_state_t    next_state;
	logic [15:0]     status;
	logic [15:0]     next_status;
	logic            next_brake;
	logic            next_axis_enable;
	logic [FB_W-1:0] fb;
	logic [FB_W-1:0] next_fb;
	logic [3:0]      restore_done;
	logic [3:0]      next_restore_done;
	logic [3:0]      next_restore_pulse;

	function automatic logic [15:0] status_of(input drive_state_t s);
		logic [15:0] v;
		v = `SW_INIT;
		unique case (s)
			ST_INIT:        v = `SW_INIT;
			ST_FAULTLESS:   v = `SW_FAULTLESS;
			ST_READY:       v = `SW_READY;
			ST_WAIT_ENABLE: v = `SW_WAIT_ENABLE;
			ST_RUNNING:     v = `SW_RUNNING;
			ST_QUICK_STOP:  v = `SW_QUICK_STOP;
			ST_FAULT_STOP:  v = `SW_FAULT_STOP;
			ST_FAULT:       v = `SW_FAULT;
		endcase
		return v;
	endfunction

	function automatic logic word_is(input logic valid, input logic [15:0] w,
		input logic [15:0] code);
		return valid && (w == code);
	endfunction

	// state machine
	always_comb begin
		logic v;
		logic [15:0] w;
		v = link.cw_valid;
		w = link.cw;
		next_state = state;
		unique case (state)
			ST_INIT: begin
				if (init_done) begin
					next_state = ST_FAULTLESS;
				end
			end
			ST_FAULTLESS: begin
				if (word_is(v, w, `CW_SHUTDOWN)) begin
					next_state = ST_READY;
				end
			end
			ST_READY: begin
				if (word_is(v, w, `CW_SWITCH_ON)) begin
					next_state = ST_WAIT_ENABLE;
				end else if (word_is(v, w, `CW_DISABLE)) begin
					next_state = ST_FAULTLESS;
				end
			end
			ST_WAIT_ENABLE: begin
				if (word_is(v, w, `CW_ENABLE)) begin
					next_state = ST_RUNNING;
				end else if (word_is(v, w, `CW_SHUTDOWN)) begin
					next_state = ST_READY;
				end else if (word_is(v, w, `CW_DISABLE)) begin
					next_state = ST_FAULTLESS;
				end
			end
			ST_RUNNING: begin
				if (word_is(v, w, `CW_SWITCH_ON)) begin
					next_state = ST_WAIT_ENABLE;
				end else if (word_is(v, w, `CW_SHUTDOWN)) begin
					next_state = ST_READY;
				end else if (word_is(v, w, `CW_DISABLE)) begin
					next_state = ST_FAULTLESS;
				end else if (word_is(v, w, `CW_QUICK_STOP)) begin
					next_state = ST_QUICK_STOP;
				end
			end
			ST_QUICK_STOP: begin
				// a resume word in the same cycle as halt_done wins: the master asked last
				if (word_is(v, w, `CW_ENABLE)) begin
					next_state = ST_RUNNING;
				end else if (halt_done) begin
					next_state = ST_FAULTLESS;
				end
			end
			ST_FAULT_STOP: begin
				// reaction lasts as long as the alarm is unresolved
				if (!fault) begin
					next_state = ST_FAULT;
				end
			end
			ST_FAULT: begin
				if (word_is(v, w, `CW_FAULT_RESET)) begin
					next_state = ST_FAULTLESS;
				end
			end
		endcase
		// fault overrides any command; words not matched above are ignored
		if (fault && state != ST_FAULT_STOP) begin
			next_state = ST_FAULT_STOP;
		end
	end

	always_comb begin
		next_status = status_of(next_state);
		next_brake = !(next_state == ST_RUNNING || next_state == ST_QUICK_STOP);
		// axis only powered in running and quick stop; fault states stay off
		next_axis_enable = (next_state == ST_RUNNING) ||
			(next_state == ST_QUICK_STOP);
		next_fb = fb;
		if (state == ST_RUNNING || state == ST_QUICK_STOP) begin
			next_fb = actual_fb;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= ST_INIT;
			status <= `SW_INIT;
			brake <= 1'b1;
			axis_enable <= 1'b0;
			fb <= '0;
		end else begin
			state <= next_state;
			status <= next_status;
			brake <= next_brake;
			axis_enable <= next_axis_enable;
			fb <= next_fb;
		end
	end

	// restore of factory defaults
	always_comb begin
		logic key_ok;
		key_ok = link.rs_valid && (link.rs_data == `RESTORE_KEY);
		next_restore_pulse = 4'h0;
		next_restore_done = restore_done;
		if (key_ok) begin
			unique case (link.rs_sub)
				`SUB_ALL: begin
					next_restore_pulse = 4'h1;
					next_restore_done[0] = 1'b1;
				end
				`SUB_COMM: begin
					next_restore_pulse = 4'h2;
					next_restore_done[1] = 1'b1;
				end
				`SUB_PROFILE: begin
					next_restore_pulse = 4'h4;
					next_restore_done[2] = 1'b1;
				end
				`SUB_MAKER: begin
					next_restore_pulse = 4'h8;
					next_restore_done[3] = 1'b1;
				end
				default: begin
					next_restore_pulse = 4'h0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			restore_pulse <= 4'h0;
			restore_done <= 4'h0;
		end else begin
			restore_pulse <= next_restore_pulse;
			restore_done <= next_restore_done;
		end
	end

	assign link.status = status;
	assign link.rs_done = restore_done;
	assign link.fb = fb;

endmodule

// ---- src/drive_params.svh ----
/*
 * constants of the drive state machine link: control word codes, status
 * word values, restore subindices and the restore key.
 * assumes it is included by bare name from the package and both ends.
 */
// Contract
// - power-up enters init, status 0x0000
// - init done goes faultless, fault goes fault-stop
// - word 0x0006 gives ready, status 0x0231
// - word 0x0007 gives waiting-to-enable, status 0x0233
// - word 0x000F while waiting gives running
// - word 0x0000 returns to faultless, status 0x0250
// - word 0x0002 while running gives quick stop
// - quick stop passes on to faultless
// - word 0x0F in quick stop resumes running
// - detected fault enters fault-stop, status 0x021F
// - fault reaction ends in fault, status 0x0218
// - word 0x80 in fault gives faultless
// - during init brake engaged, axis disabled
// - unresolved alarm keeps axis disabled
// - only control words cause non-automatic moves
// - key on subindex 2 restores communication group
// - key on subindex 3 restores profile group
// - key on subindex 4 restores maker group
// - master: ready, enable, homing, then motion
// - actual position or velocity reported during motion
`ifndef DRIVE_PARAMS_SVH
`define DRIVE_PARAMS_SVH

`define CW_DISABLE      16'h0000
`define CW_QUICK_STOP   16'h0002
`define CW_SHUTDOWN     16'h0006
`define CW_SWITCH_ON    16'h0007
`define CW_ENABLE       16'h000F
`define CW_FAULT_RESET  16'h0080

`define SW_INIT         16'h0000
`define SW_FAULTLESS    16'h0250
`define SW_READY        16'h0231
`define SW_WAIT_ENABLE  16'h0233
`define SW_RUNNING      16'h0237
`define SW_QUICK_STOP   16'h0217
`define SW_FAULT_STOP   16'h021F
`define SW_FAULT        16'h0218

`define RESTORE_KEY     32'h64616F6C
`define SUB_ALL         8'h01
`define SUB_COMM        8'h02
`define SUB_PROFILE     8'h03
`define SUB_MAKER       8'h04
`define RESTORE_GROUPS  4

`endif

// ---- src/drive_pkg.sv ----
/*
 * types shared by both ends of the drive link.
 * assumes drive_params.svh is on the include path.
 */
package drive_pkg;
	`include "drive_params.svh"

	typedef enum logic [3:0] {
		ST_INIT,
		ST_FAULTLESS,
		ST_READY,
		ST_WAIT_ENABLE,
		ST_RUNNING,
		ST_QUICK_STOP,
		ST_FAULT_STOP,
		ST_FAULT
	} drive_state_t;

	typedef logic [15:0] word_t;
endpackage

// ---- src/drive_link_if.sv ----
/*
 * link between the fieldbus master end and the drive end.
 * assumes both ends run on the same clk; strobes are one cycle wide.
 */
`timescale 1ns/1ps
interface drive_link_if #(parameter int FB_W = 32);
	logic            cw_valid;
	logic [15:0]     cw;
	logic [15:0]     status;
	logic            rs_valid;
	logic [7:0]      rs_sub;
	logic [31:0]     rs_data;
	logic [3:0]      rs_done;
	logic [FB_W-1:0] fb;

	modport drive (
		input  cw_valid,
		input  cw,
		input  rs_valid,
		input  rs_sub,
		input  rs_data,
		output status,
		output rs_done,
		output fb
	);

	modport master (
		output cw_valid,
		output cw,
		output rs_valid,
		output rs_sub,
		output rs_data,
		input  status,
		input  rs_done,
		input  fb
	);
endinterface

// ---- src/master_end.sv ----
/*
 * master end: turns user commands into control word and restore strobes,
 * and gates enabling and motion by the reported status.
 * assumes user inputs are on clk; drive answers come over the link.
 */
`timescale 1ns/1ps
`include "drive_params.svh"
module master_end
	import drive_pkg::*;
#(
	parameter int FB_W = 32
) (
	input  wire logic        clk,
	input  wire logic        reset,
	drive_link_if.master     link,
	input  wire logic        cmd_valid,
	input  wire logic [15:0] cmd_word,
	input  wire logic        rst_valid,
	input  wire logic [7:0]  rst_sub,
	input  wire logic [31:0] rst_data,
	input  wire logic        homed,
	output logic             cmd_refused,
	output logic [15:0]      status_word,
	output logic [FB_W-1:0]  feedback,
	output logic [3:0]       restore_done,
	output logic             motion_allowed
);

	generate
		if (FB_W < 8 || FB_W > 32) begin : g_bad_width
			$error("master_end: FB_W must lie in 8..32");
		end
	endgenerate

	logic        cw_valid;
	logic [15:0] cw;
	logic        rs_valid;
	logic [7:0]  rs_sub;
	logic [31:0] rs_data;
	logic        next_cw_valid;
	logic [15:0] next_cw;
	logic        next_rs_valid;
	logic [7:0]  next_rs_sub;
	logic [31:0] next_rs_data;
	logic        next_refused;
	logic        next_motion;

	always_comb begin
		logic enable_ok;
		// enable only once the drive reports it is waiting, or to resume a stop
		enable_ok = (link.status == `SW_WAIT_ENABLE) ||
			(link.status == `SW_QUICK_STOP);
		next_cw_valid = 1'b0;
		next_refused = 1'b0;
		next_cw = cw;
		if (cmd_valid) begin
			if (cmd_word == `CW_ENABLE && !enable_ok) begin
				next_refused = 1'b1;
			end else begin
				next_cw_valid = 1'b1;
				next_cw = cmd_word;
			end
		end
		next_rs_valid = rst_valid;
		next_rs_sub = rst_valid ? rst_sub : rs_sub;
		next_rs_data = rst_valid ? rst_data : rs_data;
		next_motion = (link.status == `SW_RUNNING) && homed;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cw_valid <= 1'b0;
			cw <= `CW_DISABLE;
			rs_valid <= 1'b0;
			rs_sub <= 8'h00;
			rs_data <= 32'h00000000;
			cmd_refused <= 1'b0;
			status_word <= `SW_INIT;
			feedback <= '0;
			restore_done <= 4'h0;
			motion_allowed <= 1'b0;
		end else begin
			cw_valid <= next_cw_valid;
			cw <= next_cw;
			rs_valid <= next_rs_valid;
			rs_sub <= next_rs_sub;
			rs_data <= next_rs_data;
			cmd_refused <= next_refused;
			status_word <= link.status;
			feedback <= link.fb;
			restore_done <= link.rs_done;
			motion_allowed <= next_motion;
		end
	end

	assign link.cw_valid = cw_valid;
	assign link.cw = cw;
	assign link.rs_valid = rs_valid;
	assign link.rs_sub = rs_sub;
	assign link.rs_data = rs_data;

endmodule

// ---- verif/drive_link_checker.sv ----
/* checker on the drive link: status moves on control words, restore flags.
   assumes one clk, reset synchronous high, fault raised only while running. */
`timescale 1ns/1ps
module drive_link_checker #(
	parameter int FB_W = 32
) (
	input wire logic            clk,
	input wire logic            reset,
	input wire logic            cw_valid,
	input wire logic [15:0]     cw,
	input wire logic [15:0]     status,
	input wire logic            rs_valid,
	input wire logic [7:0]      rs_sub,
	input wire logic [31:0]     rs_data,
	input wire logic [3:0]      rs_done,
	input wire logic [FB_W-1:0] fb
);
	logic       key_ok;
	logic [3:0] sub_bit;
	assign key_ok  = rs_valid && rs_data == 32'h64616F6C && rs_sub inside {[8'h01:8'h04]};
	assign sub_bit = 4'h1 << (rs_sub[1:0] - 2'h1);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	property p_init; $fell(reset) |-> status == 16'h0000; endproperty
	a_init: assert property (p_init) else $error("status not clear after reset");
	property p_ready;
		cw_valid && cw == 16'h0006 && status inside {16'h0250, 16'h0233, 16'h0237}
		|=> status == 16'h0231;
	endproperty
	a_ready: assert property (p_ready) else $error("ready not reached");
	property p_wait;
		cw_valid && cw == 16'h0007 && status inside {16'h0231, 16'h0237} |=> status == 16'h0233;
	endproperty
	a_wait: assert property (p_wait) else $error("wait state not reached");
	property p_run;
		cw_valid && cw == 16'h000F && status == 16'h0233 |=> status == 16'h0237;
	endproperty
	a_run: assert property (p_run) else $error("running not reached");
	property p_off;
		cw_valid && cw == 16'h0000 && status inside {16'h0231, 16'h0233, 16'h0237}
		|=> status == 16'h0250;
	endproperty
	a_off: assert property (p_off) else $error("faultless not reached");
	property p_qs;
		cw_valid && cw == 16'h0002 && status == 16'h0237 |=> status == 16'h0217;
	endproperty
	a_qs: assert property (p_qs) else $error("quick stop not reached");
	property p_resume;
		cw_valid && cw == 16'h000F && status == 16'h0217 |=> status == 16'h0237;
	endproperty
	a_resume: assert property (p_resume) else $error("resume failed");
	property p_clear;
		cw_valid && cw == 16'h0080 && status == 16'h0218 |=> status == 16'h0250;
	endproperty
	a_clear: assert property (p_clear) else $error("fault not cleared");
	// only ready and waiting states: init, quick stop and fault stop move on their own inputs
	property p_hold; !cw_valid && status inside {16'h0231, 16'h0233} |=> $stable(status); endproperty
	a_hold: assert property (p_hold) else $error("status moved without word");
	property p_restore; key_ok |=> (rs_done & $past(sub_bit)) == $past(sub_bit); endproperty
	a_restore: assert property (p_restore) else $error("restore flag not set");
	property p_keep; rs_valid && !key_ok |=> rs_done == $past(rs_done); endproperty
	a_keep: assert property (p_keep) else $error("bad restore changed flags");
	// feedback only follows the axis while running or stopping
	property p_fb; !(status inside {16'h0237, 16'h0217}) |=> $stable(fb); endproperty
	a_fb: assert property (p_fb) else $error("feedback moved outside motion");
endmodule

// ---- verif/drive_state_machine_ctrl_tb.sv ----
/* testbench: master end and drive end joined by the link, driven from the
   master user side. assumes the design files and package are compiled first. */
`timescale 1ns/1ps
module drive_state_machine_ctrl_tb;
	logic        clk = 1'b0;
	logic        reset, init_done, fault, halt_done, homed;
	logic        cmd_valid, rst_valid, brake, axis_enable, cmd_refused, motion_allowed;
	logic [15:0] cmd_word, status_word;
	logic [7:0]  rst_sub;
	logic [31:0] rst_data, actual_fb, feedback;
	logic [3:0]  restore_pulse, restore_done;
	int          failures, cmp_count;
	logic [15:0] tw [23] = '{16'h0007, 16'h0006, 16'h0007, 16'h0006, 16'h0000, 16'h0006,
		16'h0007, 16'h000F, 16'h0006, 16'h0007, 16'h000F, 16'h0007, 16'h000F, 16'h0000,
		16'h0006, 16'h0007, 16'h0000, 16'h0006, 16'h0007, 16'h000F, 16'h0002, 16'h000F,
		16'h0002};
	logic [15:0] ts [23] = '{16'h0250, 16'h0231, 16'h0233, 16'h0231, 16'h0250, 16'h0231,
		16'h0233, 16'h0237, 16'h0231, 16'h0233, 16'h0237, 16'h0233, 16'h0237, 16'h0250,
		16'h0231, 16'h0233, 16'h0250, 16'h0231, 16'h0233, 16'h0237, 16'h0217, 16'h0237,
		16'h0217};
	drive_link_if #(.FB_W(32)) link ();
	drive_end #(.FB_W(32)) u_drive_end (.clk(clk), .reset(reset), .link(link),
		.init_done(init_done), .fault(fault), .halt_done(halt_done), .actual_fb(actual_fb),
		.brake(brake), .axis_enable(axis_enable), .restore_pulse(restore_pulse));
	master_end #(.FB_W(32)) u_master_end (.clk(clk), .reset(reset), .link(link),
		.cmd_valid(cmd_valid), .cmd_word(cmd_word), .rst_valid(rst_valid), .rst_sub(rst_sub),
		.rst_data(rst_data), .homed(homed), .cmd_refused(cmd_refused),
		.status_word(status_word), .feedback(feedback), .restore_done(restore_done),
		.motion_allowed(motion_allowed));
	drive_link_checker #(.FB_W(32)) u_drive_link_checker (.clk(clk), .reset(reset),
		.cw_valid(link.cw_valid), .cw(link.cw), .status(link.status),
		.rs_valid(link.rs_valid), .rs_sub(link.rs_sub), .rs_data(link.rs_data),
		.rs_done(link.rs_done), .fb(link.fb));
	always #12.5 clk = ~clk;
	task automatic chk(input logic [33:0] act, input logic [33:0] exp);
		cmp_count++;
		if (act !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, act, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// refusal stands one cycle only, so it is looked at right after the taking edge
	task automatic send(input logic [15:0] w, input logic refused, input logic [15:0] st);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_word  <= w;
		@(posedge clk);
		cmd_valid <= 1'b0;
		#1;
		chk(cmd_refused, refused);
		tick(2);
		chk(status_word, st);
	endtask
	task automatic rstore(input logic [7:0] sub, input logic [31:0] d, input logic [3:0] p,
		input logic [3:0] done);
		@(posedge clk);
		rst_valid <= 1'b1;
		rst_sub   <= sub;
		rst_data  <= d;
		@(posedge clk);
		rst_valid <= 1'b0;
		tick(1);
		chk(restore_pulse, p);
		tick(1);
		chk(restore_done, done);
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#2000000;
		failures++;
		results();
	end
	initial begin
		{reset, homed} = 2'b11;
		{init_done, fault, halt_done, cmd_valid, rst_valid} = 5'h00;
		{cmd_word, rst_sub, rst_data} = 56'h0;
		actual_fb = 32'h0000A5C3;
		failures  = 0;
		cmp_count = 0;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		tick(2);
		chk(status_word, 16'h0000);
		chk({brake, axis_enable}, 2'b10);
		@(posedge clk);
		init_done <= 1'b1;
		tick(3);
		chk(status_word, 16'h0250);
		send(16'h000F, 1'b1, 16'h0250);
		for (int i = 0; i < 23; i++) send(tw[i], 1'b0, ts[i]);
		chk({brake, axis_enable, feedback}, {2'b01, actual_fb});
		@(posedge clk);
		halt_done <= 1'b1;
		tick(3);
		chk(status_word, 16'h0250);
		send(16'h0006, 1'b0, 16'h0231);
		send(16'h0007, 1'b0, 16'h0233);
		send(16'h000F, 1'b0, 16'h0237);
		tick(2);
		chk(motion_allowed, 1'b1);
		@(posedge clk);
		homed <= 1'b0;
		tick(2);
		chk(motion_allowed, 1'b0);
		@(posedge clk);
		homed <= 1'b1;
		tick(2);
		chk(motion_allowed, 1'b1);
		@(posedge clk);
		fault <= 1'b1;
		tick(3);
		chk({status_word, axis_enable}, {16'h021F, 1'b0});
		@(posedge clk);
		fault <= 1'b0;
		actual_fb <= 32'h00003C5A;
		tick(3);
		chk(status_word, 16'h0218);
		chk(feedback, 32'h0000A5C3);
		send(16'h0080, 1'b0, 16'h0250);
		rstore(8'h01, 32'h12345678, 4'h0, 4'h0);
		rstore(8'h05, 32'h64616F6C, 4'h0, 4'h0);
		for (int i = 1; i < 5; i++)
			rstore(8'(i), 32'h64616F6C, 4'(1 << (i - 1)), 4'((1 << i) - 1));
		// second reset with an alarm present: init must take the fault-stop path
		@(posedge clk);
		{reset, init_done, fault} <= 3'b101;
		tick(2);
		@(posedge clk);
		reset <= 1'b0;
		tick(2);
		chk({status_word, restore_done, brake, axis_enable}, {16'h021F, 4'h0, 2'b10});
		results();
	end
endmodule
